//--- hdl/lsd_pkg.sv
// Constants, register map and carrier type for the low-side driver register bank.
// Assumes a 32-bit APB with byte addresses; each register takes one aligned word.
package lsd_pkg;

   // ==========================================================================
   // Register indices; the byte address is four times the index.
   localparam int unsigned IDX_CONFIG  = 1;
   localparam int unsigned IDX_TRIM    = 2;
   localparam int unsigned IDX_PROT    = 3;
   localparam int unsigned IDX_OLSTAT  = 5;
   localparam int unsigned IDX_IRQMASK = 6;
   localparam int unsigned IDX_IRQSTAT = 7;

   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0]  ADDR_CONFIG  = 8'(IDX_CONFIG * 4);
   localparam logic [7:0]  ADDR_TRIM    = 8'(IDX_TRIM * 4);
   localparam logic [7:0]  ADDR_PROT    = 8'(IDX_PROT * 4);
   localparam logic [7:0]  ADDR_OLSTAT  = 8'(IDX_OLSTAT * 4);
   localparam logic [7:0]  ADDR_IRQMASK = 8'(IDX_IRQMASK * 4);
   localparam logic [7:0]  ADDR_IRQSTAT = 8'(IDX_IRQSTAT * 4);

   // ==========================================================================
   // Field positions.
   localparam int unsigned NUM_DRV       = 2;
   localparam int unsigned CFG_EN_LSB    = 0;
   localparam int unsigned CFG_OLE_LSB   = 2;
   localparam int unsigned TRIM_LSB      = 0;
   localparam int unsigned PROT_DIS_BIT  = 7;
   localparam int unsigned CLAMP_BIT     = 6;
   localparam int unsigned LIVE_OC_LSB   = 0;

   // ==========================================================================
   // Reset values.
   localparam logic [1:0]  EN_RST    = 2'h0;
   localparam logic [1:0]  OLE_RST   = 2'h0;
   localparam logic [1:0]  TRIM_RST  = 2'h0;
   localparam logic        PROT_RST  = 1'h0;
   localparam logic        CLAMP_RST = 1'h0;
   localparam logic [1:0]  MASK_RST  = 2'h0;

   // ==========================================================================
   // APB request carrier.
   typedef struct packed {
      logic               psel;
      logic               penable;
      logic               pwrite;
      logic [ADDR_W-1:0]  paddr;
      logic [31:0]        pwdata;
   } lsd_apb_req_t;

endpackage

//--- hdl/lsd_regs.sv
// Register bank and protection logic for two low-side driver stages.
// Assumes comparator inputs are asynchronous, gate source and mode come from clk_i logic.
`timescale 1ns/1ps

// Overview of operation
// - Each driver enable bit in driver_config powers its driver when 1 and shuts it down when 0.
// - Open-load detection runs only when its enable bit is 1, the driver is on and the source is off.
// - Open-load status follows the sensed pin only while detection runs, 1 meaning current at or above threshold.
// - open_load_status reads at any time and ignores writes.
// - driver_config reads and writes at any time in any mode.
// - The trim test register loads from flash right after reset is released.
// - Both test registers read at any time and accept writes only in special mode.
// - The 2-bit trim decodes one-hot to the over-current threshold for both drivers.
// - Test bit 7 set disables over-current gate protection for both drivers.
// - Test bit 6 set requests a shifted active-clamp threshold.
// - Two test status bits show each live over-current comparator result.
// - While an over-current flag is set its gate is forced off, then returns to the source.
module lsd_regs (
   // Clock and reset.
   input  wire logic                 clk_i,
   input  wire logic                 resetn_i,
   // APB slave.
   input  wire lsd_pkg::lsd_apb_req_t apb_i,
   output logic [31:0]               prdata_o,
   output logic                      pready_o,
   output logic                      pslverr_o,
   // Mode and flash trim.
   input  wire logic                 special_mode_i,
   input  wire logic [1:0]           flash_trim_i,
   // Analog side.
   input  wire logic [1:0]           gate_source_i,
   input  wire logic [1:0]           oc_cmp_i,
   input  wire logic [1:0]           open_load_sense_i,
   output logic [1:0]                driver_enable_o,
   output logic [1:0]                ol_detect_on_o,
   output logic [1:0]                gate_o,
   output logic [3:0]                oc_trim_onehot_o,
   output logic                      oc_protect_disable_o,
   output logic                      clamp_shift_o,
   // Interrupt.
   output logic                      irq_o
);

   // ==========================================================================
   // Declarations.
   logic [1:0]  driver_enable_q;
   logic [1:0]  ol_detect_enable_q;
   logic [1:0]  trim_q;
   logic        protect_disable_q;
   logic        clamp_shift_q;
   logic [1:0]  irq_mask_q;
   logic [1:0]  oc_flag_q;
   logic [1:0]  open_load_flag_q;
   logic        load_pending_q;
   logic [1:0]  oc_meta_q;
   logic [1:0]  oc_sync_q;
   logic [1:0]  ol_meta_q;
   logic [1:0]  ol_sync_q;
   logic [1:0]  detect_on;
   logic [1:0]  oc_event;
   logic        setup;
   logic        wr_commit;
   logic        mapped;
   logic [31:0] rdata_d;

   // ==========================================================================
   // Bus phases. The answer is computed in the setup cycle so pready can come from a flop.
   assign setup     = apb_i.psel & ~apb_i.penable;
   assign wr_commit = apb_i.psel & apb_i.penable & pready_o & apb_i.pwrite;

   // Read mux; unmapped addresses read zero and flag an error.
   always_comb begin
      rdata_d = 32'h0000_0000;
      mapped  = 1'b1;
      case (apb_i.paddr)
         lsd_pkg::ADDR_CONFIG: begin
            rdata_d[lsd_pkg::CFG_EN_LSB +: 2]  = driver_enable_q;
            rdata_d[lsd_pkg::CFG_OLE_LSB +: 2] = ol_detect_enable_q;
         end
         lsd_pkg::ADDR_TRIM: begin
            rdata_d[lsd_pkg::TRIM_LSB +: 2] = trim_q;
         end
         lsd_pkg::ADDR_PROT: begin
            rdata_d[lsd_pkg::PROT_DIS_BIT]     = protect_disable_q;
            rdata_d[lsd_pkg::CLAMP_BIT]        = clamp_shift_q;
            rdata_d[lsd_pkg::LIVE_OC_LSB +: 2] = oc_sync_q;
         end
         lsd_pkg::ADDR_OLSTAT: begin
            rdata_d[1:0] = open_load_flag_q;
         end
         lsd_pkg::ADDR_IRQMASK: begin
            rdata_d[1:0] = irq_mask_q;
         end
         lsd_pkg::ADDR_IRQSTAT: begin
            rdata_d[1:0] = oc_flag_q;
         end
         default: begin
            mapped = 1'b0;
         end
      endcase
   end

   // Answer flops; one wait-free access cycle after each setup cycle.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pready_o  <= 1'b0;
         prdata_o  <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else begin
         pready_o  <= setup;
         prdata_o  <= setup ? rdata_d : 32'h0000_0000;
         pslverr_o <= setup & ~mapped;
      end
   end

   // ==========================================================================
   // Configuration and mask registers, writable in every mode.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         driver_enable_q    <= lsd_pkg::EN_RST;
         ol_detect_enable_q <= lsd_pkg::OLE_RST;
         irq_mask_q         <= lsd_pkg::MASK_RST;
      end else if (wr_commit) begin
         if (apb_i.paddr == lsd_pkg::ADDR_CONFIG) begin
            driver_enable_q    <= apb_i.pwdata[lsd_pkg::CFG_EN_LSB +: 2];
            ol_detect_enable_q <= apb_i.pwdata[lsd_pkg::CFG_OLE_LSB +: 2];
         end
         if (apb_i.paddr == lsd_pkg::ADDR_IRQMASK) begin
            irq_mask_q <= apb_i.pwdata[1:0];
         end
      end
   end

   // ==========================================================================
   // Trim register. The flash value is caught by a clocked load at the first edge
   // after release, since an asynchronous reset may only load constants.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         load_pending_q <= 1'b1;
         trim_q         <= lsd_pkg::TRIM_RST;
      end else if (load_pending_q) begin
         load_pending_q <= 1'b0;
         trim_q         <= flash_trim_i;
      end else if (wr_commit && special_mode_i && apb_i.paddr == lsd_pkg::ADDR_TRIM) begin
         trim_q <= apb_i.pwdata[lsd_pkg::TRIM_LSB +: 2];
      end
   end

   // Protection test register; the live status bits are read-only.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         protect_disable_q <= lsd_pkg::PROT_RST;
         clamp_shift_q     <= lsd_pkg::CLAMP_RST;
      end else if (wr_commit && special_mode_i && apb_i.paddr == lsd_pkg::ADDR_PROT) begin
         protect_disable_q <= apb_i.pwdata[lsd_pkg::PROT_DIS_BIT];
         clamp_shift_q     <= apb_i.pwdata[lsd_pkg::CLAMP_BIT];
      end
   end

   // ==========================================================================
   // Comparator synchronisers; the first stage feeds only the second.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         oc_meta_q <= 2'h0;
         oc_sync_q <= 2'h0;
         ol_meta_q <= 2'h0;
         ol_sync_q <= 2'h0;
      end else begin
         oc_meta_q <= oc_cmp_i;
         oc_sync_q <= oc_meta_q;
         ol_meta_q <= open_load_sense_i;
         ol_sync_q <= ol_meta_q;
      end
   end

   // ==========================================================================
   // Per-driver flags and gate control.
   for (genvar g = 0; g < lsd_pkg::NUM_DRV; g++) begin : g_drv
      assign detect_on[g] = ol_detect_enable_q[g] & driver_enable_q[g] & ~gate_source_i[g];
      assign oc_event[g]  = oc_sync_q[g] & driver_enable_q[g];

      // Sticky flag; a new event beats a write-one clear in the same cycle.
      always_ff @(posedge clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            oc_flag_q[g] <= 1'b0;
         end else if (oc_event[g]) begin
            oc_flag_q[g] <= 1'b1;
         end else if (wr_commit && apb_i.paddr == lsd_pkg::ADDR_IRQSTAT && apb_i.pwdata[g]) begin
            oc_flag_q[g] <= 1'b0;
         end
      end

      // Open-load status is zero from the cycle after the monitor goes idle, so stale data cannot linger.
      always_ff @(posedge clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            open_load_flag_q[g] <= 1'b0;
         end else begin
            open_load_flag_q[g] <= detect_on[g] & ol_sync_q[g];
         end
      end

      // Gate and detect outputs.
      always_ff @(posedge clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            gate_o[g]         <= 1'b0;
            ol_detect_on_o[g] <= 1'b0;
         end else begin
            gate_o[g] <= gate_source_i[g] & driver_enable_q[g]
                         & ~(oc_flag_q[g] & ~protect_disable_q);
            ol_detect_on_o[g] <= detect_on[g];
         end
      end
   end

   // ==========================================================================
   // Analog control outputs and the interrupt line.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         driver_enable_o      <= lsd_pkg::EN_RST;
         oc_trim_onehot_o     <= 4'h1;
         oc_protect_disable_o <= lsd_pkg::PROT_RST;
         clamp_shift_o        <= lsd_pkg::CLAMP_RST;
         irq_o                <= 1'b0;
      end else begin
         driver_enable_o      <= driver_enable_q;
         oc_trim_onehot_o     <= 4'h1 << trim_q;
         oc_protect_disable_o <= protect_disable_q;
         clamp_shift_o        <= clamp_shift_q;
         irq_o                <= |(oc_flag_q & irq_mask_q);
      end
   end

   // ==========================================================================
   // Assertions.
   property p_enable_out;
      @(posedge clk_i) disable iff (!resetn_i)
      1'b1 |=> driver_enable_o == $past(driver_enable_q);
   endproperty
   a_enable_out: assert property (p_enable_out) else $error("driver enable output wrong");

   property p_detect;
      @(posedge clk_i) disable iff (!resetn_i)
      ol_detect_on_o != 2'h0 |-> $past(ol_detect_enable_q & driver_enable_q & ~gate_source_i) != 2'h0;
   endproperty
   a_detect: assert property (p_detect) else $error("detection active without cause");

   property p_ol_idle;
      @(posedge clk_i) disable iff (!resetn_i)
      driver_enable_q == 2'h0 ##1 driver_enable_q == 2'h0 |-> open_load_flag_q == 2'h0;
   endproperty
   a_ol_idle: assert property (p_ol_idle) else $error("open-load status set while off");

   property p_olstat_ro;
      @(posedge clk_i) disable iff (!resetn_i)
      wr_commit && apb_i.paddr == lsd_pkg::ADDR_OLSTAT && detect_on == 2'h0
      |=> open_load_flag_q == 2'h0;
   endproperty
   a_olstat_ro: assert property (p_olstat_ro) else $error("open-load status took a write");

   property p_cfg_write;
      @(posedge clk_i) disable iff (!resetn_i)
      wr_commit && apb_i.paddr == lsd_pkg::ADDR_CONFIG
      |=> driver_enable_q == $past(apb_i.pwdata[1:0]) ##1 driver_enable_o == $past(driver_enable_q);
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

   property p_trim_guard;
      @(posedge clk_i) disable iff (!resetn_i)
      !load_pending_q && !(wr_commit && special_mode_i) |=> $stable(trim_q) && $stable(protect_disable_q);
   endproperty
   a_trim_guard: assert property (p_trim_guard) else $error("test register changed outside special mode");

   property p_onehot;
      @(posedge clk_i) disable iff (!resetn_i)
      !load_pending_q |=> oc_trim_onehot_o == (4'h1 << $past(trim_q)) && $onehot(oc_trim_onehot_o);
   endproperty
   a_onehot: assert property (p_onehot) else $error("trim decode wrong");

   property p_gate_forced_off;
      @(posedge clk_i) disable iff (!resetn_i)
      oc_flag_q[0] && !protect_disable_q |=> !gate_o[0];
   endproperty
   a_gate_forced_off: assert property (p_gate_forced_off) else $error("gate on during over-current");

   // The release edge itself still runs the reset branch, so the load is only
   // due from the first edge at which reset was already seen high.
   property p_flash_load;
      @(posedge clk_i) disable iff (!resetn_i)
      load_pending_q && resetn_i |=> trim_q == $past(flash_trim_i) && !load_pending_q;
   endproperty
   a_flash_load: assert property (p_flash_load) else $error("flash trim not loaded");

   property p_unmapped;
      @(posedge clk_i) disable iff (!resetn_i)
      setup && !mapped |=> pready_o && pslverr_o && prdata_o == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access answered wrongly");

   c_oc_trip:   cover property (@(posedge clk_i) disable iff (!resetn_i) oc_event[1] ##1 oc_flag_q[1]);
   c_open_load: cover property (@(posedge clk_i) disable iff (!resetn_i) open_load_flag_q[0]);
   c_irq:       cover property (@(posedge clk_i) disable iff (!resetn_i) $rose(irq_o));

endmodule

//--- test/tb_top.sv
// Self-checking bench for the low-side driver register bank.
// Assumes lsd_pkg and lsd_regs are compiled first; the bench drives every port itself.
`timescale 1ns/1ps

module tb_top;
   // ==========================================================================
   // Signals and bookkeeping.
   logic                  clk_i;
   logic                  resetn_i;
   lsd_pkg::lsd_apb_req_t apb_i;
   logic [31:0]           prdata_o;
   logic                  pready_o;
   logic                  pslverr_o;
   logic                  special_mode_i;
   logic [1:0]            flash_trim_i;
   logic [1:0]            gate_source_i;
   logic [1:0]            oc_cmp_i;
   logic [1:0]            open_load_sense_i;
   logic [1:0]            driver_enable_o;
   logic [1:0]            ol_detect_on_o;
   logic [1:0]            gate_o;
   logic [3:0]            oc_trim_onehot_o;
   logic                  oc_protect_disable_o;
   logic                  clamp_shift_o;
   logic                  irq_o;
   int                    num_errors;
   int                    n_tests;
   int                    seed;
   int                    cycles = 0;
   logic [31:0]           rdat;
   logic [31:0]           wdat;
   logic                  rerr;
   logic [1:0]            exp_trim;

   // The clock runs at 125 MHz.
   initial clk_i = 1'b0;
   always #4 clk_i = ~clk_i;

   lsd_regs lsd_regs_inst (
      .clk_i(clk_i), .resetn_i(resetn_i), .apb_i(apb_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .special_mode_i(special_mode_i),
      .flash_trim_i(flash_trim_i), .gate_source_i(gate_source_i), .oc_cmp_i(oc_cmp_i),
      .open_load_sense_i(open_load_sense_i), .driver_enable_o(driver_enable_o),
      .ol_detect_on_o(ol_detect_on_o), .gate_o(gate_o), .oc_trim_onehot_o(oc_trim_onehot_o),
      .oc_protect_disable_o(oc_protect_disable_o), .clamp_shift_o(clamp_shift_o),
      .irq_o(irq_o));

   // ==========================================================================
   // Expectation functions.
   function automatic logic [3:0] onehot(input logic [1:0] t);
      return 4'h1 << t;
   endfunction

   // Gate is on when sourced and enabled, unless a flag forces it off.
   function automatic logic [1:0] gexp(input logic [1:0] s, input logic [1:0] e,
                                       input logic [1:0] f, input logic pd);
      return s & e & ~(f & {2{~pd}});
   endfunction

   // Detection runs only on an enabled, detecting driver whose source is off.
   function automatic logic [1:0] olexp(input logic [3:0] c, input logic [1:0] s,
                                        input logic [1:0] n);
      return n & c[3:2] & c[1:0] & ~s;
   endfunction

   // ==========================================================================
   // Closing report, comparison and bus tasks.
   task automatic results();
      if (num_errors == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask

   // One APB transfer; the request stands until pready is seen high at an edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      apb_i <= '{1'b1, 1'b0, w, a, d};
      @(posedge clk_i);
      apb_i.penable <= 1'b1;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         num_errors++;
         results();
      end
      rdat = prdata_o;
      rerr = pslverr_o;
      apb_i <= '0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rdat);
      chk("pslverr", 32'h0, 32'(rerr));
   endtask

   // A hang ends the run as a failure.
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 4000) begin
         num_errors++;
         results();
      end
   end

   // ==========================================================================
   // Main sequence.
   initial begin
      seed = 83307;
      num_errors = 0;
      n_tests = 0;
      resetn_i = 1'b0;
      apb_i = '0;
      special_mode_i = 1'b0;
      flash_trim_i = 2'($random(seed));
      gate_source_i = 2'h0;
      oc_cmp_i = 2'h0;
      open_load_sense_i = 2'h0;
      exp_trim = flash_trim_i;
      cyc(2);
      resetn_i <= 1'b1;
      cyc(3);
      rd(lsd_pkg::ADDR_TRIM, 32'(exp_trim), "trim");
      chk("onehot", 32'(onehot(exp_trim)), 32'(oc_trim_onehot_o));
      rd(lsd_pkg::ADDR_PROT, 32'h0, "prot");
      // Random config traffic, alternating the mode; upper bits must drop.
      for (int i = 0; i < 4; i++) begin
         special_mode_i <= 1'(i);
         wdat = $random(seed);
         apb(1'b1, lsd_pkg::ADDR_CONFIG, wdat);
         cyc(2);
         rd(lsd_pkg::ADDR_CONFIG, wdat & 32'hf, "config");
         chk("enable", 32'(wdat[1:0]), 32'(driver_enable_o));
      end
      // Every trim code, each preceded by a refused write outside special mode.
      for (int t = 0; t < 4; t++) begin
         special_mode_i <= 1'b0;
         apb(1'b1, lsd_pkg::ADDR_TRIM, 32'(exp_trim + 2'h1));
         rd(lsd_pkg::ADDR_TRIM, 32'(exp_trim), "trim");
         special_mode_i <= 1'b1;
         exp_trim = 2'(t);
         apb(1'b1, lsd_pkg::ADDR_TRIM, ($random(seed) & 32'hfffffffc) | 32'(t));
         cyc(2);
         rd(lsd_pkg::ADDR_TRIM, 32'(exp_trim), "trim");
         chk("onehot", 32'(onehot(exp_trim)), 32'(oc_trim_onehot_o));
      end
      special_mode_i <= 1'b0;
      apb(1'b1, lsd_pkg::ADDR_PROT, 32'hc0);
      rd(lsd_pkg::ADDR_PROT, 32'h0, "prot");
      special_mode_i <= 1'b1;
      apb(1'b1, lsd_pkg::ADDR_PROT, 32'h40);
      cyc(2);
      rd(lsd_pkg::ADDR_PROT, 32'h40, "prot");
      chk("clamp", 32'h1, 32'(clamp_shift_o));
      chk("pdis", 32'h0, 32'(oc_protect_disable_o));
      // Open-load detection with one driver sourced on.
      special_mode_i <= 1'b0;
      apb(1'b1, lsd_pkg::ADDR_CONFIG, 32'hf);
      cyc(5);
      gate_source_i <= 2'b01;
      open_load_sense_i <= 2'b11;
      cyc(5);
      chk("ol_on", 32'(olexp(4'hf, 2'b01, 2'b11)), 32'(ol_detect_on_o));
      chk("gate", 32'(gexp(2'b01, 2'b11, 2'b00, 1'b0)), 32'(gate_o));
      apb(1'b1, lsd_pkg::ADDR_OLSTAT, 32'hff);
      rd(lsd_pkg::ADDR_OLSTAT, 32'(olexp(4'hf, 2'b01, 2'b11)), "olstat");
      gate_source_i <= 2'b00;
      apb(1'b1, lsd_pkg::ADDR_CONFIG, 32'h7);
      cyc(5);
      rd(lsd_pkg::ADDR_OLSTAT, 32'(olexp(4'h7, 2'b00, 2'b11)), "olstat");
      // Over-current on driver 0 with its interrupt unmasked.
      open_load_sense_i <= 2'b00;
      gate_source_i <= 2'b11;
      apb(1'b1, lsd_pkg::ADDR_CONFIG, 32'h3);
      apb(1'b1, lsd_pkg::ADDR_IRQMASK, 32'h1);
      rd(lsd_pkg::ADDR_IRQMASK, 32'h1, "irqmask");
      cyc(3);
      chk("gate", 32'(gexp(2'b11, 2'b11, 2'b00, 1'b0)), 32'(gate_o));
      oc_cmp_i <= 2'b01;
      cyc(6);
      oc_cmp_i <= 2'b00;
      cyc(2);
      chk("gate", 32'(gexp(2'b11, 2'b11, 2'b01, 1'b0)), 32'(gate_o));
      chk("irq", 32'h1, 32'(irq_o));
      rd(lsd_pkg::ADDR_IRQSTAT, 32'h1, "irqstat");
      apb(1'b1, lsd_pkg::ADDR_IRQSTAT, 32'h1);
      cyc(2);
      chk("irq", 32'h0, 32'(irq_o));
      chk("gate", 32'(gexp(2'b11, 2'b11, 2'b00, 1'b0)), 32'(gate_o));
      // Driver 1 event stays masked but still latches its flag.
      oc_cmp_i <= 2'b10;
      cyc(6);
      oc_cmp_i <= 2'b00;
      cyc(2);
      chk("irq", 32'h0, 32'(irq_o));
      rd(lsd_pkg::ADDR_IRQSTAT, 32'h2, "irqstat");
      apb(1'b1, lsd_pkg::ADDR_IRQSTAT, 32'h3);
      rd(lsd_pkg::ADDR_IRQSTAT, 32'h0, "irqstat");
      // Protection disabled: the gate stays on and the live status shows.
      special_mode_i <= 1'b1;
      apb(1'b1, lsd_pkg::ADDR_PROT, 32'h80);
      oc_cmp_i <= 2'b11;
      cyc(6);
      chk("pdis", 32'h1, 32'(oc_protect_disable_o));
      chk("gate", 32'(gexp(2'b11, 2'b11, 2'b11, 1'b1)), 32'(gate_o));
      rd(lsd_pkg::ADDR_PROT, 32'h83, "prot");
      oc_cmp_i <= 2'b00;
      // Unmapped places answer with an error and read zero.
      foreach (rdat[i]) begin
         if (i < 3) begin
            apb(1'b1, 8'(i * 16 + 32), 32'hffffffff);
            apb(1'b0, 8'(i * 16 + 32), 32'h0);
            chk("unmapped", 32'h0, rdat);
            chk("pslverr", 32'h1, 32'(rerr));
         end
      end
      results();
   end
endmodule
